//--- core/ctp_timer.v
// compact 10-bit count-up timer with period and full-width comparators, pwm and compare output
// assumes: one 50 MHz clock, axi4-lite master on the same clock, pins driven through i/o muxes
//
// Contract
// [RULE1] period field compares against counter top three bits; zero means 1024 clocks
// [RULE2] period field zero lets the counter overflow at maximum instead of matching
// [RULE3] mode bits: 00 compare output, 10 pwm, 11 timer/counter, 01 undefined
// [RULE4] software stops timer before mode change; no pin use in timer mode
// [RULE5] compare mode full match: 00 hold, 01 low, 10 high, 11 toggle
// [RULE6] pwm mode function: 00 inactive, 01 active, 10 waveform, 11 undefined
// [RULE7] software changes function bits only while timer is off
// [RULE8] compare mode level bit gives initial pin level, 0 low 1 high
// [RULE9] pwm mode level bit gives active level; ignored in timer mode
// [RULE10] invert bit inverts the pin signal; ignored in timer mode
// [RULE11] pwm role swap: 0 period field is period; 1 full value is period
// [RULE12] clear select high clears on full match; low on period match or overflow
// [RULE13] pwm mode ignores clear select; role assignment decides the clear
// [RULE14] compare mode clear select low sets both flags on their matches
// [RULE15] compare mode clear select high never sets the period flag
// [RULE16] clear select high, full value zero: overflow at 3FF, no full flag
// [RULE17] compare mode pin changes only on full match, never on period match
// [RULE18] counter-on rising edge returns pin to initial level
// [RULE19] timer mode counts and flags like compare mode but drives no pin
// [RULE20] pwm mode sets a flag on each full match and each period match
// [RULE21] pwm duty at or above period gives 100 percent duty
// [RULE22] pwm counting continues while output is forced inactive or active
// [RULE23] counter-on rising edge zeroes counter; falling edge stops and holds count
// [RULE24] full compare value is 10 bits, compared with every counter bit
// [RULE25] pwm output active from each clear until duty match, then inactive
`timescale 1ns/1ns
`include "ctp_regs.vh"
module ctp_timer #(
  parameter CNT_W    = 10,
  parameter PRESCALE = `CTP_PRESCALE_DEF
) (
  input  wire        clock,
  input  wire        rst_n,
  input  wire [4:0]  s_axi_awaddr,
  input  wire        s_axi_awvalid,
  output wire        s_axi_awready,
  input  wire [31:0] s_axi_wdata,
  input  wire [3:0]  s_axi_wstrb,
  input  wire        s_axi_wvalid,
  output wire        s_axi_wready,
  output reg  [1:0]  s_axi_bresp,
  output reg         s_axi_bvalid,
  input  wire        s_axi_bready,
  input  wire [4:0]  s_axi_araddr,
  input  wire        s_axi_arvalid,
  output wire        s_axi_arready,
  output reg  [31:0] s_axi_rdata,
  output reg  [1:0]  s_axi_rresp,
  output reg         s_axi_rvalid,
  input  wire        s_axi_rready,
  output reg         timer_out_pin_a,
  output reg         timer_out_pin_b,
  output reg         timer_out_pin_en,
  output wire        full_cmp_flag,
  output wire        period_cmp_flag
);

  // ****************
  // register storage
  // ****************
  reg  [7:0]       mode_ctrl_q;
  reg  [7:0]       run_ctrl_q;
  reg  [CNT_W-1:0] full_cmp_value_q;
  reg  [1:0]       flags_q;
  reg  [CNT_W-1:0] count_q;
  reg  [15:0]      pre_q;
  reg              on_dly_q;
  reg              out_q;
  reg              aw_hold_q;
  reg              w_hold_q;
  reg  [4:0]       awaddr_q;
  reg  [31:0]      wdata_q;
  reg  [3:0]       wstrb_q;

  wire [1:0] op_mode   = {mode_ctrl_q[`CTP_MODE_HI], mode_ctrl_q[`CTP_MODE_LO]};
  wire [1:0] out_func  = {mode_ctrl_q[`CTP_FUNC_HI], mode_ctrl_q[`CTP_FUNC_LO]};
  wire       out_level_ctrl   = mode_ctrl_q[`CTP_LEVEL];
  wire       out_invert       = mode_ctrl_q[`CTP_INVERT];
  wire       pwm_role_swap    = mode_ctrl_q[`CTP_SWAP];
  wire       clear_source_sel = mode_ctrl_q[`CTP_CLRSEL];
  wire       counter_on       = run_ctrl_q[`CTP_RUN_ON];
  wire [2:0] period_field_bits = run_ctrl_q[`CTP_PER_HI:`CTP_PER_LO];

  assign full_cmp_flag   = flags_q[`CTP_FLAG_FULL];
  assign period_cmp_flag = flags_q[`CTP_FLAG_PER];

  // ****************
  // axi4-lite write path
  // ****************
  // address and data are latched independently, so either may arrive first
  wire do_write = aw_hold_q && w_hold_q && !s_axi_bvalid;
  assign s_axi_awready = !aw_hold_q;
  assign s_axi_wready  = !w_hold_q;
  // decode on the word address; the two low address bits are ignored
  wire [4:0] aw_word = {awaddr_q[4:2], 2'b00};
  wire wr_mode  = do_write && (aw_word == `CTP_OFF_MODE_CTRL) && wstrb_q[0];
  wire wr_run   = do_write && (aw_word == `CTP_OFF_RUN_CTRL) && wstrb_q[0];
  wire wr_full  = do_write && (aw_word == `CTP_OFF_FULL_CMP);
  wire wr_flags = do_write && (aw_word == `CTP_OFF_FLAGS) && wstrb_q[0];

  function valid_addr;
    input [4:0] a;
    begin
      valid_addr = ({a[4:2], 2'b00} <= `CTP_OFF_FLAGS);
    end
  endfunction

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      aw_hold_q    <= 1'b0;
      w_hold_q     <= 1'b0;
      awaddr_q     <= 5'h00;
      wdata_q      <= 32'h0000_0000;
      wstrb_q      <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= 2'h0;
    end
    else
    begin
      if (s_axi_awvalid && !aw_hold_q)
      begin
        aw_hold_q <= 1'b1;
        awaddr_q  <= s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_hold_q)
      begin
        w_hold_q <= 1'b1;
        wdata_q  <= s_axi_wdata;
        wstrb_q  <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold_q    <= 1'b0;
        w_hold_q     <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= valid_addr(awaddr_q) ? 2'h0 : 2'h2;
      end
      else if (s_axi_bvalid && s_axi_bready)
        s_axi_bvalid <= 1'b0;
    end
  end

  // ****************
  // axi4-lite read path
  // ****************
  assign s_axi_arready = !s_axi_rvalid;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h0000_0000;
      s_axi_rresp  <= 2'h0;
    end
    else if (s_axi_arvalid && !s_axi_rvalid)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= valid_addr(s_axi_araddr) ? 2'h0 : 2'h2;
      case ({s_axi_araddr[4:2], 2'b00})
        `CTP_OFF_MODE_CTRL: s_axi_rdata <= {24'h000000, mode_ctrl_q};
        `CTP_OFF_RUN_CTRL:  s_axi_rdata <= {24'h000000, run_ctrl_q};
        `CTP_OFF_FULL_CMP:  s_axi_rdata <= {{(32-CNT_W){1'b0}}, full_cmp_value_q};
        `CTP_OFF_COUNT:     s_axi_rdata <= {{(32-CNT_W){1'b0}}, count_q};
        `CTP_OFF_FLAGS:     s_axi_rdata <= {{30{1'b0}}, flags_q};
        default:            s_axi_rdata <= 32'h0000_0000;
      endcase
    end
    else if (s_axi_rvalid && s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end

  // ****************
  // control registers
  // ****************
  // undefined mode and function codes are stored as written and act as do-nothing
  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      mode_ctrl_q      <= `CTP_RST_MODE_CTRL;
      run_ctrl_q       <= `CTP_RST_RUN_CTRL;
      full_cmp_value_q <= `CTP_RST_FULL_CMP;
    end
    else
    begin
      if (wr_mode)
        mode_ctrl_q <= wdata_q[7:0];
      if (wr_run)
        run_ctrl_q <= wdata_q[7:0];
      if (wr_full)
      begin
        if (wstrb_q[0])
          full_cmp_value_q[7:0] <= wdata_q[7:0];
        if (wstrb_q[1])
          full_cmp_value_q[CNT_W-1:8] <= wdata_q[CNT_W-1:8];
      end
    end
  end

  // ****************
  // timer clock enable
  // ****************
  // the timer clock is a one-cycle enable from a divider of the system clock
  wire tick = counter_on && (pre_q == PRESCALE[15:0] - 16'h0001);

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      pre_q <= 16'h0000;
    else if (!counter_on || tick)
      pre_q <= 16'h0000;
    else
      pre_q <= pre_q + 16'h0001;
  end

  // ****************
  // comparators and counter
  // ****************
  wire on_rise  = counter_on && !on_dly_q;
  wire is_pwm   = (op_mode == `CTP_MODE_PWM);
  wire is_cmp   = (op_mode == `CTP_MODE_CMP);
  wire is_tmr   = (op_mode == `CTP_MODE_TMR);
  // the period comparator looks at the next count, so field N clears after exactly N*128 ticks
  // and field 000 hits as the counter wraps, giving the 1024-tick period
  wire [CNT_W-1:0] cnt_nxt = count_q + 1'b1;
  wire per_hit  = (cnt_nxt[CNT_W-1:CNT_W-3] == period_field_bits) &&
                  (cnt_nxt[CNT_W-4:0] == {(CNT_W-3){1'b0}});        // see [RULE1]
  wire full_hit = (full_cmp_value_q != {CNT_W{1'b0}}) &&
                  (count_q == full_cmp_value_q);                    // see [RULE24] see [RULE16]
  wire ovf      = (count_q == `CTP_CNT_MAX);
  // period-field clear: match, or overflow when the field is zero
  wire per_clr  = per_hit || ((period_field_bits == 3'h0) && ovf);  // see [RULE2]
  wire full_clr = full_hit || ovf;
  // pwm: role bit names the comparator that sets the period
  wire clr_src  = is_pwm ? (pwm_role_swap ? full_clr : per_clr)     // see [RULE11] see [RULE13]
                         : (clear_source_sel ? full_clr : per_clr); // see [RULE12]
  wire run_mode = is_pwm || is_cmp || is_tmr;                        // see [RULE3]
  // no compare on the switch-on edge: the held count of the last run must not raise a flag
  wire step     = tick && run_mode && !on_rise;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_q  <= {CNT_W{1'b0}};
      on_dly_q <= 1'b0;
    end
    else
    begin
      on_dly_q <= counter_on;
      if (on_rise)
        count_q <= {CNT_W{1'b0}};                                   // see [RULE23]
      else if (step)
        count_q <= clr_src ? {CNT_W{1'b0}} : count_q + 1'b1;
    end
  end

  // ****************
  // interrupt flags
  // ****************
  // flags are write-one-to-clear; a match in the same cycle wins over the clear
  wire set_full = step && full_hit;                                  // see [RULE20]
  wire set_per  = step && per_hit && (is_pwm || !clear_source_sel);  // see [RULE14] see [RULE15] see [RULE19]

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
      flags_q <= 2'h0;
    else
    begin
      flags_q[`CTP_FLAG_FULL] <= set_full |
        (flags_q[`CTP_FLAG_FULL] & ~(wr_flags & wdata_q[`CTP_FLAG_FULL]));
      flags_q[`CTP_FLAG_PER] <= set_per |
        (flags_q[`CTP_FLAG_PER] & ~(wr_flags & wdata_q[`CTP_FLAG_PER]));
    end
  end

  // ****************
  // output logic
  // ****************
  // duty edge: the non-period comparator; duty 1024 from a zero field never falls
  wire [CNT_W:0] duty_ext = pwm_role_swap ?
                            {period_field_bits == 3'h0, period_field_bits, {(CNT_W-3){1'b0}}} :
                            {1'b0, full_cmp_value_q};
  reg            pwm_act_q;

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      out_q     <= 1'b0;
      pwm_act_q <= 1'b0;
    end
    else
    begin
      if (on_rise)
      begin
        out_q     <= out_level_ctrl;                                 // see [RULE18] see [RULE8]
        pwm_act_q <= ({1'b0, {CNT_W{1'b0}}} != duty_ext);
      end
      else if (step && is_cmp && full_hit)                           // see [RULE17]
      begin
        case (out_func)                                              // see [RULE5]
          2'h1:    out_q <= 1'b0;
          2'h2:    out_q <= 1'b1;
          2'h3:    out_q <= ~out_q;
          default: out_q <= out_q;
        endcase
      end
      // waveform keeps running whatever the function bits force
      if (!on_rise && step && is_pwm)                                // see [RULE22]
      begin
        if (clr_src)
          pwm_act_q <= ({1'b0, {CNT_W{1'b0}}} != duty_ext);          // see [RULE25]
        else if ({1'b0, count_q + 1'b1} == duty_ext)
          pwm_act_q <= 1'b0;                                         // see [RULE21]
      end
    end
  end

  reg pin_d;
  always @*
  begin
    case (out_func)                                                  // see [RULE6]
      2'h0:    pin_d = ~out_level_ctrl;
      2'h1:    pin_d = out_level_ctrl;
      2'h2:    pin_d = pwm_act_q ? out_level_ctrl : ~out_level_ctrl; // see [RULE9]
      default: pin_d = ~out_level_ctrl;
    endcase
    if (!is_pwm)
      pin_d = out_q;
  end

  always @(posedge clock or negedge rst_n)
  begin
    if (!rst_n)
    begin
      timer_out_pin_a  <= 1'b0;
      timer_out_pin_b  <= 1'b0;
      timer_out_pin_en <= 1'b0;
    end
    else
    begin
      timer_out_pin_a  <= pin_d ^ out_invert;                        // see [RULE10]
      timer_out_pin_b  <= pin_d ^ out_invert;
      timer_out_pin_en <= is_cmp || is_pwm;                          // see [RULE19] see [RULE4]
    end
  end

endmodule // ctp_timer

//--- core/ctp_regs.vh
// register offsets, field positions, reset values and timing counts of the compact timer
// assumes: included by ctp_timer.v only
`ifndef CTP_REGS_VH
`define CTP_REGS_VH
// ****************
// register offsets
// ****************
`define CTP_OFF_MODE_CTRL 5'h00
`define CTP_OFF_RUN_CTRL  5'h04
`define CTP_OFF_FULL_CMP  5'h08
`define CTP_OFF_COUNT     5'h0C
`define CTP_OFF_FLAGS     5'h10
// ****************
// field positions
// ****************
`define CTP_MODE_HI     7
`define CTP_MODE_LO     6
`define CTP_FUNC_HI     5
`define CTP_FUNC_LO     4
`define CTP_LEVEL       3
`define CTP_INVERT      2
`define CTP_SWAP        1
`define CTP_CLRSEL      0
`define CTP_RUN_ON      3
`define CTP_PER_HI      2
`define CTP_PER_LO      0
`define CTP_FLAG_FULL   0
`define CTP_FLAG_PER    1
// ****************
// reset values and counts
// ****************
`define CTP_RST_MODE_CTRL 8'h00
`define CTP_RST_RUN_CTRL  8'h00
`define CTP_RST_FULL_CMP  10'h000
`define CTP_CNT_MAX       10'h3FF
`define CTP_PERIOD_UNIT   128
`define CTP_PRESCALE_DEF  1
`define CTP_MODE_CMP      2'h0
`define CTP_MODE_PWM      2'h2
`define CTP_MODE_TMR      2'h3
`endif

//--- tb/ctp_timer_chk.sv
// checker: bus handshakes, flag and pin relations of the compact timer
// assumes: bound into ctp_timer, one clock, rst_n async active low
`timescale 1ns/1ns
module ctp_timer_chk (
  input logic        clock,
  input logic        rst_n,
  input logic        s_axi_awvalid,
  input logic        s_axi_awready,
  input logic        s_axi_wvalid,
  input logic        s_axi_wready,
  input logic        s_axi_bvalid,
  input logic        s_axi_bready,
  input logic        s_axi_arvalid,
  input logic        s_axi_arready,
  input logic [31:0] s_axi_rdata,
  input logic [1:0]  s_axi_rresp,
  input logic        s_axi_rvalid,
  input logic        s_axi_rready,
  input logic        timer_out_pin_a,
  input logic        timer_out_pin_b,
  input logic        timer_out_pin_en,
  input logic        full_cmp_flag,
  input logic        period_cmp_flag
);
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // ****************
  // assertions
  // ****************
  pins_same_a: assert property (timer_out_pin_a == timer_out_pin_b)
    else $error("output pins differ");
  rvalid_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read answer dropped early");
  bvalid_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write answer dropped early");
  read_lat_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  write_lat_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |-> ##[1:2] s_axi_bvalid)
    else $error("write answer late");
  ar_ready_a: assert property (s_axi_arready == !s_axi_rvalid)
    else $error("read address ready wrong");
  // flags are sticky: only a register write may clear them
  flag_clear_a: assert property ($fell(full_cmp_flag) || $fell(period_cmp_flag) |-> $rose(s_axi_bvalid))
    else $error("flag cleared without a write");
  err_data_a: assert property (s_axi_rvalid && s_axi_rresp != 2'h0 |-> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("refused read carries data");
  cv_full: cover property ($rose(full_cmp_flag));
  cv_per: cover property ($rose(period_cmp_flag));
  cv_en: cover property ($fell(timer_out_pin_en));
  cv_err: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
endmodule // ctp_timer_chk

bind ctp_timer ctp_timer_chk u_chk (.clock, .rst_n, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
  .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .timer_out_pin_a, .timer_out_pin_b,
  .timer_out_pin_en, .full_cmp_flag, .period_cmp_flag);

//--- tb/ctp_timer_tb_top.sv
// testbench: drives ctp_timer over axi4-lite, watches pins and read answers
// assumes: prescale 1, offsets and flag bits as in the designer's map
`timescale 1ns/1ns
module ctp_timer_tb_top;
  logic        clock = 1'b0;
  logic        rst_n = 1'b0;
  logic [4:0]  s_axi_awaddr = 5'h00;
  logic [4:0]  s_axi_araddr = 5'h00;
  logic [31:0] s_axi_wdata = 32'h0;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0]  s_axi_bresp, s_axi_rresp;
  logic [31:0] s_axi_rdata;
  logic        timer_out_pin_a, timer_out_pin_b, timer_out_pin_en, full_cmp_flag, period_cmp_flag;
  logic [33:0] exp_q[$];
  logic [33:0] expb_q[$];
  logic [15:0] rnd = 16'h9E06;
  int          error_cnt = 0;
  int          n_checks = 0;
  ctp_timer uut (.clock, .rst_n, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .timer_out_pin_a, .timer_out_pin_b, .timer_out_pin_en, .full_cmp_flag,
    .period_cmp_flag);
  always #10 clock = ~clock;
  // ****************
  // helpers
  // ****************
  function automatic logic [15:0] lfsr(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction
  task automatic chk(input string nm, input logic [33:0] seen, input logic [33:0] e);
    n_checks++;
    if (seen !== e)
    begin
      error_cnt++;
      $display("BAD %s exp %h seen %h", nm, e, seen);
    end
  endtask
  task end_of_test;
    $display("checks %0d mismatches %0d", n_checks, error_cnt);
    if (error_cnt == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  // handshakes sampled on the falling edge so the comb readies are settled
  task automatic wr(input logic [4:0] a, input logic [31:0] d);
    logic ta, tw, tb;
    int   n = 0;
    @(posedge clock);
    expb_q.push_back({32'h0, ((a > 5'h10) ? 2'h2 : 2'h0)});
    s_axi_awaddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    s_axi_bready  <= 1'b1;
    do
    begin
      @(negedge clock);
      ta = s_axi_awready;
      tw = s_axi_wready;
      tb = s_axi_bvalid;
      @(posedge clock);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
      n++;
    end
    while (!tb && n < 64);
    if (!tb) chk("bvalid", 34'h0, 34'h1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic rd(input logic [4:0] a, input logic [33:0] e);
    logic ta, tr;
    int   n = 0;
    @(posedge clock);
    exp_q.push_back(e);
    s_axi_araddr  <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready  <= 1'b1;
    do
    begin
      @(negedge clock);
      ta = s_axi_arready;
      tr = s_axi_rvalid;
      @(posedge clock);
      if (ta) s_axi_arvalid <= 1'b0;
      n++;
    end
    while (!tr && n < 64);
    if (!tr) chk("rvalid", 34'h0, 34'h1);
    s_axi_rready <= 1'b0;
  endtask
  always @(posedge clock)
    if (s_axi_rvalid === 1'b1 && s_axi_rready === 1'b1 && exp_q.size() > 0)
      chk("rdata", {s_axi_rresp, s_axi_rdata}, exp_q.pop_front());
  always @(posedge clock)
    if (s_axi_bvalid === 1'b1 && s_axi_bready === 1'b1 && expb_q.size() > 0)
      chk("bresp", {32'h0, s_axi_bresp}, expb_q.pop_front());
  task automatic run(input logic [7:0] mode, input logic [9:0] full, input logic [2:0] per);
    wr(5'h04, 32'h0);
    wr(5'h10, 32'h3);
    wr(5'h00, {24'h0, mode});
    wr(5'h08, {22'h0, full});
    wr(5'h04, {28'h0, 1'b1, per});
  endtask
  task automatic pin_at(input int t, input logic e);
    repeat (t) @(posedge clock);
    @(negedge clock);
    chk("pin", {33'h0, timer_out_pin_a}, {33'h0, e});
  endtask
  task automatic duty(input int t, input int lo, input int hi);
    int h = 0;
    repeat (t)
    begin
      @(negedge clock);
      h += (timer_out_pin_a === 1'b1);
    end
    chk("duty", {33'h0, h >= lo && h <= hi}, 34'h1);
  endtask
  initial
  begin
    #400000;
    error_cnt++;
    end_of_test;
  end
  // ****************
  // main sequence
  // ****************
  initial
  begin
    logic [7:0]  pm[7] = '{8'hA8, 8'hA0, 8'hAC, 8'hA8, 8'h88, 8'h98, 8'hAB};
    int          pf[7] = '{32, 32, 32, 200, 32, 32, 256};
    int          pt[7] = '{256, 256, 256, 256, 256, 256, 512};
    int          pe[7] = '{64, 192, 192, 256, 0, 256, 256};
    logic [33:0] pg[7] = '{3, 3, 3, 2, 3, 3, 3};
    logic [2:0]  ps[3] = '{1, 2, 0};
    int          p1[3] = '{130, 250, 1000};
    logic        lv;
    repeat (3) @(posedge clock);
    rst_n <= 1'b1;
    rd(5'h00, 34'h0);
    rd(5'h04, 34'h0);
    rd(5'h08, 34'h0);
    rd(5'h14, {2'h2, 32'h0});
    wr(5'h14, 32'h0);
    for (int i = 0; i < 4; i++)
    begin
      rnd = lfsr(rnd);
      wr(5'h00, {16'h0, rnd});
      rd(5'h00, {26'h0, rnd[7:0]});
      wr(5'h08, {16'h0, rnd});
      rd(5'h08, {24'h0, rnd[9:0]});
    end
    $display("test registers done");
    for (int v = 0; v < 2; v++)
      for (int f = 0; f < 4; f++)
      begin
        lv = (f != 2);
        run({2'h0, f[1:0], lv, v[0], 2'b01}, 10'd20, 3'd1);
        chk("pin_en", {33'h0, timer_out_pin_en}, 34'h1);
        pin_at(6, lv ^ v[0]);
        pin_at(26, (f == 0 ? lv : f == 2) ^ v[0]);
        rd(5'h10, 34'h1);
      end
    $display("test compare output done");
    foreach (ps[i])
    begin
      run(8'h30, 10'd20, ps[i]);
      pin_at(p1[i], 1'b1);
      pin_at(60, 1'b0);
      rd(5'h10, 34'h3);
    end
    run(8'h31, 10'd0, 3'd1);
    pin_at(1100, 1'b0);
    rd(5'h10, 34'h0);
    run(8'hF0, 10'd20, 3'd1);
    pin_at(300, 1'b0);
    chk("pin_en", {33'h0, timer_out_pin_en}, 34'h0);
    rd(5'h10, 34'h3);
    $display("test clear sources done");
    foreach (pm[i])
    begin
      run(pm[i], pf[i][9:0], 3'd1);
      repeat (20) @(posedge clock);
      duty(pt[i], pe[i] - 2, pe[i] + 2);
      rd(5'h10, pg[i]);
    end
    $display("test pwm done");
    end_of_test;
  end
endmodule // ctp_timer_tb_top
